//--- src/sfptc_pkg.sv
package sfptc_pkg;
    // ------------------------------------------------------------
    // Two-wire addressing
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_IDENT     = 7'h50;     // Byte address 0xA0 >> 1
    localparam logic [6:0] DEV_DIAG      = 7'h51;     // Byte address 0xA2 >> 1
    localparam logic [7:0] OFF_STATCTL   = 8'h6e;     // transmitter_status_control
    localparam logic [7:0] OFF_RATECTL   = 8'h76;     // Software transmit rate byte
    localparam logic [7:0] OFF_MON_FIRST = 8'h60;     // First live monitor byte
    localparam logic [7:0] OFF_MON_LAST  = 8'h69;     // Last live monitor byte
    localparam logic [6:0] MON_TOP_BIT   = 7'h4f;     // Top bit of the monitor vector
    localparam logic [3:0] BITS_BYTE     = 4'h8;      // Bits before an acknowledge
    // ------------------------------------------------------------
    // Bit positions inside transmitter_status_control
    // ------------------------------------------------------------
    localparam int B_TXOFF_STATE = 7;
    localparam int B_SOFT_OFF    = 6;
    localparam int B_RTX_PIN     = 5;
    localparam int B_RRX_PIN     = 4;
    localparam int B_SOFT_RRX    = 3;
    localparam int B_FAULT       = 2;
    localparam int B_LOS         = 1;
    localparam int B_SOFT_RTX    = 3;                 // Within OFF_RATECTL
    // ------------------------------------------------------------
    // Pin synchroniser order and reset values
    // ------------------------------------------------------------
    localparam int P_SCL   = 0;
    localparam int P_SDA   = 1;
    localparam int P_TXOFF = 2;
    localparam int P_LOS   = 3;
    localparam int P_FAULT = 4;
    localparam int P_RTX   = 5;
    localparam int P_RRX   = 6;
    localparam int NPINS   = 7;
    localparam logic [6:0] SYNC_RST = 7'h07;          // Bus idle high, transmit-off high
    // ------------------------------------------------------------
    // Two-wire slave states
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_DEV  = 9'h002,
        ST_ACKD = 9'h004,
        ST_ADDR = 9'h008,
        ST_ACKA = 9'h010,
        ST_WR   = 9'h020,
        ST_ACKW = 9'h040,
        ST_RD   = 9'h080,
        ST_MACK = 9'h100
    } sfptc_state_t;
endpackage

//--- src/sfptc_mem.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Byte memory for both pages, registered read
// ------------------------------------------------------------
module sfptc_mem (
    // Clock
    input  wire logic       clk,
    input  wire logic       ce,
    // Write side
    input  wire logic       we,
    input  wire logic [8:0] waddr,
    input  wire logic [7:0] wdata,
    // Read side
    input  wire logic [8:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:511];

    // Write and registered read
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

//--- src/sfptc_top.sv
`timescale 1ns/10ps
// How it works
// - Transmitter is off while the transmit-off pin is high, on while low unless soft disable or a latched fault holds it off.
// - Transmit-off pin left undriven means transmitter off.
// - Host may set soft disable in status-control bit 6; device obeys it.
// - Status-control bit 7 shows the transmit-off pin state.
// - Transmitter off when soft disable or transmit-off pin is set.
// - Laser fault raises the fault output and turns off the laser.
// - Fault output low when healthy, released high on fault, open collector.
// - Fault stays latched until transmit-off toggles or power cycles.
// - Status-control bit 2 mirrors the fault state.
// - Cycling transmit-off restarts fault handling after a fault.
// - Device address 0xA0 answers with a 256-byte identification page.
// - Device address 0xA2 answers with a separate 256-byte diagnostic page.
// - Diagnostic page shows live bias, power, supply, temperature, receive power.
// - Each direction's rate set by pin or software; set means gigabit.
// - Receive loss output high on lost light, mirrored in status-control bit 1.
module sfptc_top
    import sfptc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Control pins from the host
    input  wire logic        tx_off_pin,
    input  wire logic        rate_tx_pin,
    input  wire logic        rate_rx_pin,
    // Optics status from the analog front end
    input  wire logic        laser_fault_det,
    input  wire logic        los_det,
    // Live monitor values
    input  wire logic [15:0] mon_temp,
    input  wire logic [15:0] mon_vcc,
    input  wire logic [15:0] mon_bias,
    input  wire logic [15:0] mon_txpwr,
    input  wire logic [15:0] mon_rxpwr,
    // Two-wire management bus
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    // Status and control outputs
    output logic             tx_fault_o,
    output logic             tx_fault_oe_n,
    output logic             laser_off,
    output logic             receive_signal_lost,
    output logic             rate_tx_gig,
    output logic             rate_rx_gig
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NPINS-1:0] s1_r, s2_r, s3_r;
    logic             scl_rise, scl_fall, start, stop, txoff_rise;

    // Two stages for every pin, a third for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= SYNC_RST;                         // Undriven pin reads as off
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
        end else if (ce) begin
            s1_r <= {rate_rx_pin, rate_tx_pin, laser_fault_det, los_det,
                     tx_off_pin, sda_i, scl_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Bus conditions and pin edges
    assign scl_rise   = s2_r[P_SCL] & ~s3_r[P_SCL];
    assign scl_fall   = ~s2_r[P_SCL] & s3_r[P_SCL];
    assign start      = s2_r[P_SCL] & s3_r[P_SCL] & ~s2_r[P_SDA] & s3_r[P_SDA];
    assign stop       = s2_r[P_SCL] & s3_r[P_SCL] & s2_r[P_SDA] & ~s3_r[P_SDA];
    assign txoff_rise = s2_r[P_TXOFF] & ~s3_r[P_TXOFF];

    // ------------------------------------------------------------
    // Control state and two-wire slave
    // ------------------------------------------------------------
    sfptc_state_t st_r, st_nxt;
    logic [7:0]   sh_r, sh_nxt, ptr_r, ptr_nxt, rd_byte, mem_rdata;
    logic [3:0]   cnt_r, cnt_nxt;
    logic         dsel_r, dsel_nxt, rw_r, rw_nxt, oe_n_r, oe_n_nxt;
    logic         soft_off_r, soft_off_nxt, soft_rrx_r, soft_rrx_nxt;
    logic         soft_rtx_r, soft_rtx_nxt, fault_r, fault_nxt, we;
    logic         off_r, off_nxt, los_r, los_nxt, rtx_r, rtx_nxt, rrx_r, rrx_nxt;
    logic [79:0]  mon_all;
    logic [3:0]   mon_idx;
    logic         is_mon;

    // Live bytes overlay the memory on the diagnostic page
    assign mon_all = {mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr};
    assign mon_idx = 4'(ptr_r - OFF_MON_FIRST);
    assign is_mon  = (ptr_r >= OFF_MON_FIRST) && (ptr_r <= OFF_MON_LAST);

    // Byte presented to the reader
    always_comb begin
        rd_byte = mem_rdata;                          // Memory byte, either page
        if (dsel_r) begin
            if (ptr_r == OFF_STATCTL) begin
                rd_byte = {s2_r[P_TXOFF], soft_off_r, s2_r[P_RTX], s2_r[P_RRX],
                           soft_rrx_r, fault_r, s2_r[P_LOS], 1'b0};
            end else if (ptr_r == OFF_RATECTL) begin
                rd_byte = {4'h0, soft_rtx_r, 3'h0};
            end else if (is_mon) begin
                rd_byte = mon_all[(MON_TOP_BIT - {mon_idx, 3'h0}) -: 8];
            end
        end
    end

    // Next state of slave and control bits
    always_comb begin
        st_nxt       = st_r;
        sh_nxt       = sh_r;
        cnt_nxt      = cnt_r;
        ptr_nxt      = ptr_r;
        dsel_nxt     = dsel_r;
        rw_nxt       = rw_r;
        oe_n_nxt     = oe_n_r;
        soft_off_nxt = soft_off_r;
        soft_rrx_nxt = soft_rrx_r;
        soft_rtx_nxt = soft_rtx_r;
        we           = 1'b0;
        if (stop) begin
            st_nxt   = ST_IDLE;
            oe_n_nxt = 1'b1;
        end else if (start) begin
            st_nxt   = ST_DEV;
            cnt_nxt  = 4'h0;
            oe_n_nxt = 1'b1;
        end else begin
            case (st_r)
                ST_DEV, ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        sh_nxt  = {sh_r[6:0], s2_r[P_SDA]};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == BITS_BYTE) begin
                        oe_n_nxt = 1'b0;
                        if (st_r == ST_DEV) begin
                            if (sh_r[7:1] == DEV_IDENT || sh_r[7:1] == DEV_DIAG) begin
                                dsel_nxt = sh_r[1];   // Page select
                                rw_nxt   = sh_r[0];
                                st_nxt   = ST_ACKD;
                            end else begin
                                oe_n_nxt = 1'b1;      // Not ours, stay silent
                                st_nxt   = ST_IDLE;
                            end
                        end else if (st_r == ST_ADDR) begin
                            ptr_nxt = sh_r;
                            st_nxt  = ST_ACKA;
                        end else begin
                            st_nxt  = ST_ACKW;
                            ptr_nxt = ptr_r + 8'h01;
                            if (dsel_r && ptr_r == OFF_STATCTL) begin
                                soft_off_nxt = sh_r[B_SOFT_OFF];
                                soft_rrx_nxt = sh_r[B_SOFT_RRX];
                            end else if (dsel_r && ptr_r == OFF_RATECTL) begin
                                soft_rtx_nxt = sh_r[B_SOFT_RTX];
                            end else if (!(dsel_r && is_mon)) begin
                                we = 1'b1;
                            end
                        end
                    end
                end
                ST_ACKD, ST_ACKA, ST_ACKW, ST_MACK: begin
                    if (st_r == ST_MACK && scl_rise) begin
                        cnt_nxt = 4'h0;
                        if (s2_r[P_SDA]) begin
                            st_nxt = ST_IDLE;         // Master ended the read
                        end
                    end else if (scl_fall) begin
                        cnt_nxt  = 4'h0;
                        oe_n_nxt = 1'b1;
                        if ((st_r == ST_ACKD && rw_r) || st_r == ST_MACK) begin
                            sh_nxt   = rd_byte;
                            oe_n_nxt = rd_byte[7];
                            ptr_nxt  = ptr_r + 8'h01;
                            st_nxt   = ST_RD;
                        end else if (st_r == ST_ACKD) begin
                            st_nxt = ST_ADDR;
                        end else begin
                            st_nxt = ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == BITS_BYTE) begin
                            oe_n_nxt = 1'b1;
                            st_nxt   = ST_MACK;
                        end else begin
                            sh_nxt   = {sh_r[6:0], 1'b0};
                            oe_n_nxt = sh_r[6];
                        end
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Fault latch, transmitter disable, loss and rate outputs
    always_comb begin
        fault_nxt = s2_r[P_FAULT] | (fault_r & ~txoff_rise); // Set wins
        off_nxt   = s2_r[P_TXOFF] | soft_off_r | fault_r;
        los_nxt   = s2_r[P_LOS];
        rtx_nxt   = s2_r[P_RTX] | soft_rtx_r;                // Pin or software
        rrx_nxt   = s2_r[P_RRX] | soft_rrx_r;
    end

    // Register all control state
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r       <= ST_IDLE;
            sh_r       <= 8'h00;
            cnt_r      <= 4'h0;
            ptr_r      <= 8'h00;
            dsel_r     <= 1'b0;
            rw_r       <= 1'b0;
            oe_n_r     <= 1'b1;
            soft_off_r <= 1'b0;
            soft_rrx_r <= 1'b0;
            soft_rtx_r <= 1'b0;
            fault_r    <= 1'b0;                       // Power cycle clears
            off_r      <= 1'b1;
            los_r      <= 1'b0;
            rtx_r      <= 1'b0;
            rrx_r      <= 1'b0;
        end else if (ce) begin
            st_r       <= st_nxt;
            sh_r       <= sh_nxt;
            cnt_r      <= cnt_nxt;
            ptr_r      <= ptr_nxt;
            dsel_r     <= dsel_nxt;
            rw_r       <= rw_nxt;
            oe_n_r     <= oe_n_nxt;
            soft_off_r <= soft_off_nxt;
            soft_rrx_r <= soft_rrx_nxt;
            soft_rtx_r <= soft_rtx_nxt;
            fault_r    <= fault_nxt;
            off_r      <= off_nxt;
            los_r      <= los_nxt;
            rtx_r      <= rtx_nxt;
            rrx_r      <= rrx_nxt;
        end
    end

    // Both pages in one memory, page bit on top
    sfptc_mem u_mem (
        .clk   (clk),
        .ce    (ce),
        .we    (we),
        .waddr ({dsel_r, ptr_r}),
        .wdata (sh_r),
        .raddr ({dsel_r, ptr_r}),
        .rdata (mem_rdata)
    );
    // Outputs
    assign sda_o               = 1'b0;
    assign sda_oe_n            = oe_n_r;
    assign tx_fault_o          = 1'b0;
    assign tx_fault_oe_n       = fault_r;             // Released high on fault
    assign laser_off           = off_r;
    assign receive_signal_lost = los_r;
    assign rate_tx_gig         = rtx_r;
    assign rate_rx_gig         = rrx_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pin_disables: assert property (@(posedge clk) disable iff (rst)
        (ce && s2_r[P_TXOFF]) |=> laser_off) else $error("pin high but laser on");
    a_soft_disables: assert property (@(posedge clk) disable iff (rst)
        (ce && soft_off_r) |=> laser_off) else $error("soft disable ignored");
    a_or_enable: assert property (@(posedge clk) disable iff (rst)
        (ce && !s2_r[P_TXOFF] && !soft_off_r && !fault_r) |=> !laser_off)
        else $error("laser off without cause");
    a_fault_sets: assert property (@(posedge clk) disable iff (rst)
        (ce && s2_r[P_FAULT]) |=> ##1 (tx_fault_oe_n && laser_off))
        else $error("fault not reported");
    a_fault_holds: assert property (@(posedge clk) disable iff (rst)
        (ce && fault_r && !txoff_rise) |=> fault_r) else $error("fault dropped");
    a_fault_clears: assert property (@(posedge clk) disable iff (rst)
        (ce && txoff_rise && !s2_r[P_FAULT]) |=> !fault_r)
        else $error("toggle did not clear fault");
    a_soft_reset: assert property (@(posedge clk)
        $fell(rst) |-> !soft_off_r) else $error("soft disable set after reset");
    a_los_follow: assert property (@(posedge clk) disable iff (rst)
        (ce && s2_r[P_LOS]) |=> receive_signal_lost) else $error("loss not shown");
    a_rate_tx: assert property (@(posedge clk) disable iff (rst)
        (ce && soft_rtx_r) |=> rate_tx_gig) else $error("soft rate ignored");
    a_ack_release: assert property (@(posedge clk) disable iff (rst)
        (st_r == ST_IDLE) |-> sda_oe_n) else $error("bus driven while idle");
endmodule

//--- test/sfptc_host.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host board: two-wire master and pull-ups
// ------------------------------------------------------------
module sfptc_host (
    // Clock
    input  wire logic clk,
    // Two-wire bus
    output logic      scl,
    output logic      sda_w,
    input  wire logic sda_o,
    input  wire logic sda_oe_n,
    // Fault line
    input  wire logic tx_fault_o,
    input  wire logic tx_fault_oe_n,
    output logic      fault_line
);
    logic sda_m;
    // Pull-up wired AND of master and device
    assign sda_w = sda_m & (sda_oe_n | sda_o);
    // Host pull-up on the open-collector fault line
    assign fault_line = tx_fault_oe_n | tx_fault_o;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One bit slot, data set while the clock is low
    task automatic bit_slot(input logic b, output logic r);
        sda_m = b;
        hw(4);
        scl = 1'b1;
        hw(6);
        r = sda_w;
        scl = 1'b0;
        hw(2);
    endtask
    // Byte MSB first, ninth slot is the acknowledge
    task automatic byte_slot(input logic [7:0] d, input logic m_ack,
                             output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], r[i]);
        end
        bit_slot(m_ack, ack);
    endtask
    // Start, also used as repeated start
    task automatic start_c;
        sda_m = 1'b1;
        hw(4);
        scl = 1'b1;
        hw(4);
        sda_m = 1'b0;
        hw(4);
        scl = 1'b0;
        hw(2);
    endtask
    task automatic stop_c;
        sda_m = 1'b0;
        hw(4);
        scl = 1'b1;
        hw(4);
        sda_m = 1'b1;
        hw(6);
    endtask
    // Single byte write; ok when all three bytes were acknowledged
    task automatic wr(input logic [7:0] dev, input logic [7:0] addr,
                      input logic [7:0] data, output logic ok);
        logic [7:0] r;
        logic [2:0] a;
        start_c();
        byte_slot(dev, 1'b1, r, a[0]);
        byte_slot(addr, 1'b1, r, a[1]);
        byte_slot(data, 1'b1, r, a[2]);
        stop_c();
        ok = ~|a;
    endtask
    // Random read: pointer write, repeated start, one byte with no-acknowledge
    task automatic rd(input logic [7:0] dev, input logic [7:0] addr,
                      output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic [3:0] a;
        start_c();
        byte_slot(dev, 1'b1, r, a[0]);
        byte_slot(addr, 1'b1, r, a[1]);
        start_c();
        byte_slot(dev | 8'h01, 1'b1, r, a[2]);
        byte_slot(8'hff, 1'b1, d, a[3]);
        stop_c();
        ok = ~|a[2:0];
    endtask
    // Two-byte sequential read; master acknowledges the first byte
    task automatic rd2(input logic [7:0] dev, input logic [7:0] addr,
                       output logic [15:0] d, output logic ok);
        logic [7:0] r;
        logic [3:0] a;
        start_c();
        byte_slot(dev, 1'b1, r, a[0]);
        byte_slot(addr, 1'b1, r, a[1]);
        start_c();
        byte_slot(dev | 8'h01, 1'b1, r, a[2]);
        byte_slot(8'hff, 1'b0, d[15:8], a[3]);
        byte_slot(8'hff, 1'b1, d[7:0], a[3]);
        stop_c();
        ok = ~|a[2:0];
    endtask
endmodule

//--- test/sfptc_top_tb.sv
`timescale 1ns/10ps
module sfptc_top_tb
    import sfptc_pkg::*;
;
    localparam logic [7:0] A0 = 8'ha0;
    localparam logic [7:0] A2 = 8'ha2;
    logic        clk, rst, ce, tx_off_pin, rate_tx_pin, rate_rx_pin;
    logic        laser_fault_det, los_det, scl, sda_w, sda_o, sda_oe_n;
    logic        tx_fault_o, tx_fault_oe_n, fault_line, laser_off;
    logic        receive_signal_lost, rate_tx_gig, rate_rx_gig, ok;
    logic [15:0] mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr;
    int          errors, cmp_count;
    sfptc_top dut (.clk(clk), .rst(rst), .ce(ce), .tx_off_pin(tx_off_pin),
        .rate_tx_pin(rate_tx_pin), .rate_rx_pin(rate_rx_pin),
        .laser_fault_det(laser_fault_det), .los_det(los_det), .mon_temp(mon_temp),
        .mon_vcc(mon_vcc), .mon_bias(mon_bias), .mon_txpwr(mon_txpwr),
        .mon_rxpwr(mon_rxpwr), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .tx_fault_o(tx_fault_o), .tx_fault_oe_n(tx_fault_oe_n),
        .laser_off(laser_off), .receive_signal_lost(receive_signal_lost),
        .rate_tx_gig(rate_tx_gig), .rate_rx_gig(rate_rx_gig));
    sfptc_host host (.clk(clk), .scl(scl), .sda_w(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .tx_fault_o(tx_fault_o),
        .tx_fault_oe_n(tx_fault_oe_n), .fault_line(fault_line));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_chk(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d);
        host.wr(dev, a, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(dev, a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, e);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_start;
        chk({7'h00, laser_off}, 8'h01);
        chk({7'h00, fault_line}, 8'h00);
        rd_chk(A2, OFF_STATCTL, 8'h80);
        $display("test start done");
    endtask
    task automatic t_disable;
        tx_off_pin = 1'b0;
        wait_n(3);
        chk({7'h00, laser_off}, 8'h00);
        wr_chk(A2, OFF_STATCTL, 8'h40);
        chk({7'h00, laser_off}, 8'h01);
        rd_chk(A2, OFF_STATCTL, 8'h40);
        wr_chk(A2, OFF_STATCTL, 8'h00);
        chk({7'h00, laser_off}, 8'h00);
        $display("test disable done");
    endtask
    task automatic t_fault;
        laser_fault_det = 1'b1;
        wait_n(4);
        chk({6'h00, fault_line, laser_off}, 8'h03);
        // Toggle while the fault is still present does not clear it
        tx_off_pin = 1'b1;
        wait_n(4);
        tx_off_pin = 1'b0;
        laser_fault_det = 1'b0;
        wait_n(8);
        chk({6'h00, fault_line, laser_off}, 8'h03);
        rd_chk(A2, OFF_STATCTL, 8'h04);
        tx_off_pin = 1'b1;
        wait_n(4);
        chk({7'h00, fault_line}, 8'h00);
        tx_off_pin = 1'b0;
        wait_n(3);
        chk({7'h00, laser_off}, 8'h00);
        $display("test fault done");
    endtask
    task automatic t_rate;
        los_det = 1'b1;
        rate_tx_pin = 1'b1;
        rate_rx_pin = 1'b1;
        wait_n(3);
        chk({5'h00, receive_signal_lost, rate_tx_gig, rate_rx_gig}, 8'h07);
        rd_chk(A2, OFF_STATCTL, 8'h32);
        los_det = 1'b0;
        rate_tx_pin = 1'b0;
        rate_rx_pin = 1'b0;
        wr_chk(A2, OFF_STATCTL, 8'h08);
        chk({6'h00, rate_tx_gig, rate_rx_gig}, 8'h01);
        wr_chk(A2, OFF_RATECTL, 8'h08);
        chk({6'h00, rate_tx_gig, rate_rx_gig}, 8'h03);
        rd_chk(A2, OFF_STATCTL, 8'h08);
        wr_chk(A2, OFF_STATCTL, 8'h00);
        wr_chk(A2, OFF_RATECTL, 8'h00);
        chk({6'h00, rate_tx_gig, rate_rx_gig}, 8'h00);
        $display("test rate done");
    endtask
    task automatic t_pages;
        wr_chk(A0, 8'h10, 8'h5a);
        wr_chk(A2, 8'h10, 8'ha5);
        wr_chk(A0, 8'hff, 8'h3c);
        rd_chk(A0, 8'h10, 8'h5a);
        rd_chk(A2, 8'h10, 8'ha5);
        rd_chk(A0, 8'hff, 8'h3c);
        host.wr(8'ha4, 8'h10, 8'h00, ok);
        chk({7'h00, ok}, 8'h00);
        wr_chk(A2, OFF_MON_FIRST, 8'h00);
        rd_chk(A2, OFF_MON_FIRST, 8'h12);
        rd_chk(A2, 8'h63, 8'h78);
        rd_chk(A2, 8'h64, 8'h9a);
        rd_chk(A2, 8'h67, 8'hf0);
        rd_chk(A2, OFF_MON_LAST, 8'h68);
        $display("test pages done");
    endtask
    task automatic t_hold;
        logic [15:0] d;
        // Low clock enable freezes the pin path
        ce = 1'b0;
        tx_off_pin = 1'b1;
        wait_n(6);
        chk({7'h00, laser_off}, 8'h00);
        ce = 1'b1;
        wait_n(4);
        chk({7'h00, laser_off}, 8'h01);
        // Reset in mid-run clears soft disable and latched fault
        tx_off_pin = 1'b0;
        wr_chk(A2, OFF_STATCTL, 8'h40);
        laser_fault_det = 1'b1;
        wait_n(4);
        laser_fault_det = 1'b0;
        wait_n(4);
        chk({6'h00, fault_line, laser_off}, 8'h03);
        rst = 1'b1;
        wait_n(2);
        rst = 1'b0;
        wait_n(3);
        chk({6'h00, fault_line, laser_off}, 8'h00);
        // Sequential read with master acknowledge, big-endian pair
        host.rd2(A2, OFF_MON_FIRST, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d[15:8], 8'h12);
        chk(d[7:0], 8'h34);
        rd_chk(A2, OFF_STATCTL, 8'h00);
        $display("test hold done");
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        final_report();
    end
    initial begin
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        ce = 1'b1;
        tx_off_pin = 1'b1; // Undriven pin sits at its pull-up
        rate_tx_pin = 1'b0;
        rate_rx_pin = 1'b0;
        laser_fault_det = 1'b0;
        los_det = 1'b0;
        mon_temp = 16'h1234;
        mon_vcc = 16'h5678;
        mon_bias = 16'h9abc;
        mon_txpwr = 16'hdef0;
        mon_rxpwr = 16'h2468;
        wait_n(6);
        rst = 1'b0;
        wait_n(3);
        t_start();
        t_disable();
        t_fault();
        t_rate();
        t_pages();
        t_hold();
        final_report();
    end
endmodule
